// ---- src/ppa_accum.sv ----
// Summary of operation
// RL1 - four-bit chop pattern covers pulses one to four, then repeats per group
// RL2 - inverted-integration pulses are subtracted, normal ones added
// RL3 - bits 7:4 subtract pattern, set bit negates that position, lsb first pulse
// RL4 - bits 3:0 reverse pattern, set bit swaps integrator phase order
// RL5 - pattern 0xa inverts and subtracts pulses two and four
// RL6 - software programs an even pulse count when chopping
// RL7 - software should keep chopping on in continuous connection mode
// RL8 - software zeroes both converter offset trims when chopping
// RL9 - midscale bias enable adds 2048 codes to the final result
// RL10 - each slot has its own pattern register, 0x020 apart
// RL11 - float mode: precondition, disconnect anode for float time, reconnect
// RL12 - float mode bypasses the bandpass stage
// RL13 - float mode charge transfer lies inside the negative phase
// RL14 - negative integration phase is centred on the charge transfer
// RL15 - software uses even equal-length pulses, led lit in one per pair
// RL16 - suppress pattern bit per position decides if the emitter fires
// RL17 - suggested: led on pulses two and three, add those, subtract others
// RL18 - with one integration per conversion, repeat count gives pulse total
// RL19 - exactly one output write of the combined value per sample
// RL20 - software sets minimum period to cover float plus connect time
// RL21 - modulation select 0 is continuous, 0x1 is float
// RL22 - software sets float mode repeat count to a multiple of two
// RL23 - pulse position and accumulator restart at each sample
// RL24 - accumulator holds the full signed sum without overflow
`timescale 1ns/1ns
`default_nettype none
module ppa_accum
  import ppa_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // pattern register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [15:0]       reg_wdata,
  output logic      [15:0]       reg_rdata,
  // sample control
  input  wire logic              sample_start,
  input  wire logic [1:0]        sample_slot,
  input  wire logic [7:0]        num_int,
  input  wire logic [7:0]        num_repeat,
  input  wire logic [1:0]        modulation_select,
  input  wire logic              midscale_bias_enable,
  input  wire logic [9:0]        min_period,
  input  wire logic [4:0]        integ_width,
  input  wire logic [7:0]        float_time,
  output logic                   busy,
  // analog receive path and emitter
  output logic                   precon_en,
  output logic                   anode_connect,
  output logic                   bandpass_stage_bypass,
  output logic                   integ_pos,
  output logic                   integ_neg,
  output logic                   emitter_fire,
  output logic                   adc_start,
  input  wire logic              adc_valid,
  input  wire logic [ADC_W-1:0]  adc_data,
  // output buffer
  output logic                   out_wr,
  output logic [ACC_W-1:0]       out_data
);

  ////////////////////////////////////////////////////////////////////////////
  // pattern registers, one per slot

  logic [15:0]      pat_reg_ff [NUM_SLOTS];
  logic [15:0]      rd_mux;
  logic [15:0]      rdata_ff;

  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    localparam logic [15:0] SLOT_ADDR = PATTERN_BASE + 16'(g) * SLOT_STRIDE;
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        pat_reg_ff[g] <= PATTERN_RST;
      end else if (reg_wr && reg_addr == SLOT_ADDR) begin // RL10
        pat_reg_ff[g] <= reg_wdata & PATTERN_MASK;
      end
    end
  end

  always_comb begin
    rd_mux = 16'h0000;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (reg_addr == PATTERN_BASE + 16'(i) * SLOT_STRIDE) begin
        rd_mux = pat_reg_ff[i];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      rdata_ff <= rd_mux;
    end
  end

  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // sample sequencer

  ppa_state_t       state_ff;
  ppa_state_t       nxt_state;
  logic [15:0]      pat_ff;
  logic             float_ff;
  logic [1:0]       pos_ff;
  logic [15:0]      left_ff;
  logic [7:0]       ph_cnt_ff;
  logic [9:0]       us_cnt_ff;
  logic [7:0]       target;
  logic             tick;
  logic             ph_done;
  logic [15:0]      total;
  logic             rev_bit;
  logic             sub_bit;
  logic             led_off;
  logic             a_neg;

  assign total   = 16'(num_int * num_repeat); // RL18
  assign rev_bit = pat_ff[REV_LSB + 32'(pos_ff)]; // RL1 RL4
  assign sub_bit = pat_ff[SUB_LSB + 32'(pos_ff)]; // RL1 RL3
  assign led_off = pat_ff[LED_LSB + 32'(pos_ff)]; // RL16

  always_comb begin
    unique case (state_ff)
      ST_PRECON:            target = PRECON_US;
      ST_FLOAT:             target = float_time;
      ST_PHASE_A, ST_PHASE_B: target = {3'h0, integ_width};
      ST_IDLE, ST_CONVERT, ST_PAD, ST_WRITE: target = 8'h00;
    endcase
  end

  assign ph_done = tick && (ph_cnt_ff + 8'h01 >= target);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:    if (sample_start) nxt_state = (total == 16'h0000) ? ST_WRITE : ST_PRECON;
      ST_PRECON:  if (ph_done) nxt_state = float_ff ? ST_FLOAT : ST_PHASE_A; // RL11
      ST_FLOAT:   if (ph_done) nxt_state = ST_PHASE_A; // RL11
      ST_PHASE_A: if (ph_done) nxt_state = ST_PHASE_B;
      ST_PHASE_B: if (ph_done) nxt_state = ST_CONVERT;
      ST_CONVERT: if (adc_valid) nxt_state = ST_PAD;
      ST_PAD:     if (us_cnt_ff >= min_period) nxt_state = (left_ff == 16'h0000) ? ST_WRITE : ST_PRECON;
      ST_WRITE:   nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ppa_tick u_tick (
    .clock (clock),
    .nrst  (nrst),
    .clear (nxt_state != state_ff),
    .tick  (tick)
  );

  // phase and period timing in microseconds
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ph_cnt_ff <= 8'h00;
    end else if (nxt_state != state_ff) begin
      ph_cnt_ff <= 8'h00;
    end else if (tick) begin
      ph_cnt_ff <= ph_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      us_cnt_ff <= 10'h000;
    end else if (nxt_state == ST_PRECON && state_ff != ST_PRECON) begin
      us_cnt_ff <= 10'h000;
    end else if (tick && us_cnt_ff != 10'h3ff) begin
      us_cnt_ff <= us_cnt_ff + 10'h001;
    end
  end

  // per-sample configuration capture
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pat_ff   <= PATTERN_RST;
      float_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && sample_start) begin
      pat_ff   <= pat_reg_ff[sample_slot];
      float_ff <= (modulation_select == MOD_FLOAT); // RL21
    end
  end

  // pulse position and remaining pulse count
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pos_ff  <= 2'h0;
      left_ff <= 16'h0000;
    end else if (state_ff == ST_IDLE && sample_start) begin
      pos_ff  <= 2'h0; // RL23
      left_ff <= total; // RL18
    end else if (state_ff == ST_CONVERT && adc_valid) begin
      pos_ff  <= pos_ff + 2'h1; // RL1
      left_ff <= left_ff - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog path controls

  assign a_neg                 = float_ff | rev_bit; // RL4 RL5 RL13
  assign busy                  = (state_ff != ST_IDLE);
  assign precon_en             = (state_ff == ST_PRECON);
  assign bandpass_stage_bypass = float_ff; // RL12
  assign integ_neg             = (state_ff == ST_PHASE_A && a_neg) ||
                                 (state_ff == ST_PHASE_B && !a_neg); // RL14
  assign integ_pos             = (state_ff == ST_PHASE_A && !a_neg) ||
                                 (state_ff == ST_PHASE_B && a_neg);
  assign anode_connect         = float_ff ? (state_ff == ST_PHASE_A) : // RL11 RL13
                                 (state_ff == ST_PHASE_A || state_ff == ST_PHASE_B ||
                                  state_ff == ST_CONVERT || state_ff == ST_PAD);
  assign emitter_fire          = !led_off && (float_ff ? (state_ff == ST_FLOAT)
                                                       : (state_ff == ST_PHASE_A)); // RL16

  logic adc_start_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      adc_start_ff <= 1'b0;
    end else begin
      adc_start_ff <= (state_ff == ST_PHASE_B && ph_done);
    end
  end

  assign adc_start = adc_start_ff;

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and output write

  logic signed [ACC_W-1:0] acc_ff; // RL24
  logic signed [ACC_W-1:0] adc_ext;
  logic                    out_wr_ff;
  logic [ACC_W-1:0]        out_data_ff;

  assign adc_ext = ACC_W'({1'b0, adc_data});

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= '0;
    end else if (state_ff == ST_IDLE && sample_start) begin
      acc_ff <= '0; // RL23
    end else if (state_ff == ST_CONVERT && adc_valid) begin
      acc_ff <= sub_bit ? acc_ff - adc_ext : acc_ff + adc_ext; // RL2 RL3
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_wr_ff   <= 1'b0;
      out_data_ff <= '0;
    end else begin
      out_wr_ff <= (state_ff == ST_WRITE); // RL19
      if (state_ff == ST_WRITE) begin
        out_data_ff <= acc_ff + (midscale_bias_enable ? MIDSCALE_BIAS : '0); // RL9
      end
    end
  end

  assign out_wr   = out_wr_ff;
  assign out_data = out_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_pulse_done;
    state_ff == ST_CONVERT && adc_valid;
  endsequence

  sequence s_float_entry;
    state_ff == ST_PRECON && float_ff ##1 state_ff == ST_FLOAT;
  endsequence

  pos_repeat_a: assert property (s_pulse_done |=> pos_ff == $past(pos_ff) + 2'h1) else $error("pulse position did not advance"); // RL1
  acc_sign_a: assert property (s_pulse_done |=> acc_ff == ($past(sub_bit) ? $past(acc_ff) - $past(adc_ext)
                                                        : $past(acc_ff) + $past(adc_ext))) else $error("accumulate sign wrong"); // RL2
  polarity_a: assert property (state_ff == ST_PHASE_A && !float_ff |-> integ_neg == rev_bit) else $error("phase order wrong"); // RL4
  float_isolate_a: assert property (s_float_entry |-> !anode_connect && !integ_pos && !integ_neg) else $error("anode not floated"); // RL11
  bpf_bypass_a: assert property (busy |-> bandpass_stage_bypass == float_ff) else $error("bandpass bypass wrong"); // RL12
  float_neg_a: assert property (float_ff && anode_connect |-> integ_neg && !integ_pos) else $error("transfer outside negative phase"); // RL13
  emitter_pattern_a: assert property (emitter_fire |-> !pat_ff[LED_LSB + 32'(pos_ff)]) else $error("suppressed emitter fired"); // RL16
  bias_add_a: assert property (state_ff == ST_WRITE ##1 1'b1 |-> out_wr && out_data == $past(acc_ff) +
                               ($past(midscale_bias_enable) ? MIDSCALE_BIAS : '0)) else $error("output bias wrong"); // RL9
  single_write_a: assert property (out_wr |-> $past(left_ff) == 16'h0000 ##1 !out_wr) else $error("extra output write"); // RL19
  restart_a: assert property (state_ff == ST_IDLE && sample_start |=> pos_ff == 2'h0 && acc_ff == '0
                              && left_ff == $past(total)) else $error("sample did not restart"); // RL23
  slot_copy_a: assert property (reg_wr && reg_addr == 16'h012d |=> pat_reg_ff[1] == ($past(reg_wdata) & PATTERN_MASK))
    else $error("second slot pattern not written"); // RL10

endmodule
`default_nettype wire

// ---- src/ppa_pkg.sv ----
package ppa_pkg;

  // clock and time base
  localparam int         CLK_PERIOD_NS = 4;
  localparam int         US_NS         = 1000;
  localparam logic [7:0] US_CYCLES     = 8'(US_NS / CLK_PERIOD_NS);
  localparam logic [7:0] PRECON_US     = 8'h01;

  // per-slot pattern register map
  localparam int          NUM_SLOTS    = 4;
  localparam logic [15:0] PATTERN_BASE = 16'h010d;
  localparam logic [15:0] SLOT_STRIDE  = 16'h0020;
  localparam logic [15:0] PATTERN_RST  = 16'h0000;
  localparam logic [15:0] PATTERN_MASK = 16'hf0ff;
  localparam int          REV_LSB      = 0;
  localparam int          SUB_LSB      = 4;
  localparam int          LED_LSB      = 12;

  // datapath
  localparam int          ADC_W         = 16;
  localparam int          ACC_W         = 33;
  localparam logic [32:0] MIDSCALE_BIAS = 33'h000000800;

  // modulation select codes
  localparam logic [1:0] MOD_CONT  = 2'h0;
  localparam logic [1:0] MOD_FLOAT = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_PRECON  = 3'h1,
    ST_PHASE_A = 3'h2,
    ST_PHASE_B = 3'h3,
    ST_CONVERT = 3'h4,
    ST_PAD     = 3'h5,
    ST_WRITE   = 3'h6,
    ST_FLOAT   = 3'h7
  } ppa_state_t;

endpackage

// ---- src/ppa_tick.sv ----
`timescale 1ns/1ns
`default_nettype none
module ppa_tick
  import ppa_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // control
  input  wire logic clear,
  output logic      tick
);

  logic [7:0] cnt_ff;
  logic       tick_ff;

  // one-cycle enable every microsecond, realigned by clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else if (clear) begin
      // the clearing edge counts as the first cycle of the new microsecond
      cnt_ff  <= 8'h01;
      tick_ff <= 1'b0;
    end else if (cnt_ff == US_CYCLES - 8'h01) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 8'h01;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule
`default_nettype wire

// ---- testbench/ppa_adc_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ppa_adc_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // converter handshake
  input  wire logic        adc_start,
  input  wire logic        slow,
  output logic             adc_valid,
  output logic [15:0]      adc_data
);
  logic [7:0] wait_cnt;

  // one answer per request, prompt or stalled; data keeps toggling when not valid
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      adc_valid <= 1'b0;
      adc_data  <= 16'h0000;
      wait_cnt  <= 8'h00;
    end else begin
      adc_valid <= 1'b0;
      adc_data  <= ~adc_data;
      if (adc_start) begin
        wait_cnt <= slow ? 8'($urandom_range(2, 40)) : 8'h01;
      end else if (wait_cnt == 8'h01) begin
        adc_valid <= 1'b1;
        adc_data  <= 16'($urandom);
        wait_cnt  <= 8'h00;
      end else if (wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_pulse_pattern_accumulator.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_pulse_pattern_accumulator
  import ppa_pkg::*;
;
  logic              clock, nrst, reg_wr, reg_rd, sample_start, midscale_bias_enable, slow;
  logic [15:0]       reg_addr, reg_wdata, reg_rdata, pat, d;
  logic [15:0]       pat_mem [4];
  logic [1:0]        sample_slot, modulation_select, sl;
  logic [7:0]        num_int, num_repeat, float_time;
  logic [9:0]        min_period;
  logic [4:0]        integ_width;
  logic              busy, precon_en, anode_connect, bandpass_stage_bypass, integ_pos, integ_neg;
  logic              emitter_fire, adc_start, adc_valid, out_wr;
  logic [15:0]       adc_data;
  logic [32:0]       out_data;
  logic signed [32:0] acc;
  logic              pre_q = 1'b0, anode_q = 1'b0, em_seen, ph_seen, first_neg, first_an, flt;
  int                cyc, pre_cnt, flt_cnt, pos, total, nwr, nstart, fail_count, num_checks, pos_cyc;

  ppa_accum dut_u (.clock, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sample_start,
    .sample_slot, .num_int, .num_repeat, .modulation_select, .midscale_bias_enable, .min_period,
    .integ_width, .float_time, .busy, .precon_en, .anode_connect, .bandpass_stage_bypass, .integ_pos,
    .integ_neg, .emitter_fire, .adc_start, .adc_valid, .adc_data, .out_wr, .out_data);
  ppa_adc_model adc_u (.clock, .nrst, .adc_start, .slow, .adc_valid, .adc_data);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [15:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [15:0] a, input logic [15:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    check(33'(reg_rdata), 33'(exp));
  endtask

  task automatic set_pat(input logic [1:0] s, input logic [15:0] v);
    reg_write(PATTERN_BASE + SLOT_STRIDE * 16'(s), v);
    pat_mem[s] = v & PATTERN_MASK;
  endtask

  task automatic run_sample(input logic [1:0] s, input logic [7:0] ni, input logic [7:0] nr,
                            input logic [1:0] md, input logic sw);
    int n;
    n = 0;
    check(33'(nwr), 33'(nstart));
    nstart++;
    slow <= sw;
    sample_slot <= s;
    num_int <= ni;
    num_repeat <= nr;
    modulation_select <= md;
    sample_start <= 1'b1;
    @(posedge clock);
    sample_start <= 1'b0;
    if (ni * nr != 8'h00) begin
      repeat (3) @(posedge clock);
      sample_start <= 1'b1;
      sample_slot <= s + 2'h1;
      @(posedge clock);
      sample_start <= 1'b0;
    end
    while (nwr < nstart && n < 40000) begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // expected behaviour tracked from the ports
  always @(posedge clock) begin
    if (sample_start && !busy && nrst) begin
      pat = pat_mem[sample_slot];
      flt = (modulation_select == MOD_FLOAT);
      total = num_int * num_repeat;
      pos = 0;
      acc = '0;
    end
    if (precon_en) pre_cnt = pre_q ? pre_cnt + 1 : 1;
    if (precon_en && !pre_q) begin
      em_seen = 1'b0;
      ph_seen = 1'b0;
      flt_cnt = 0;
      pos_cyc = 0;
    end
    if (integ_pos) pos_cyc++;
    if (!precon_en && pre_q) check(33'(pre_cnt), 33'(US_CYCLES));
    if (flt && !precon_en && !anode_connect && !ph_seen) flt_cnt++;
    if (flt && anode_connect && !anode_q) check(33'(flt_cnt), 33'(float_time) * 33'(US_CYCLES));
    if ((integ_pos || integ_neg) && !ph_seen) begin
      ph_seen = 1'b1;
      first_neg = integ_neg;
      first_an = anode_connect;
    end
    if (emitter_fire) em_seen = 1'b1;
    if (adc_start) begin
      check(33'(em_seen), 33'(!pat[LED_LSB + pos % 4]));
      check(33'(first_neg), flt ? 33'h1 : 33'(pat[REV_LSB + pos % 4]));
      check(33'(bandpass_stage_bypass), 33'(flt));
      check(33'(first_an), 33'h1);
      check(33'(pos_cyc), 33'(integ_width) * 33'(US_CYCLES));
    end
    if (adc_valid) begin
      if (pat[SUB_LSB + pos % 4]) acc = acc - 33'(adc_data);
      else acc = acc + 33'(adc_data);
      pos++;
    end
    if (out_wr) begin
      check(out_data, acc + (midscale_bias_enable ? MIDSCALE_BIAS : 33'h0));
      check(33'(pos), 33'(total));
      check(33'(busy), 33'h0);
      nwr++;
    end
    pre_q = precon_en;
    anode_q = anode_connect;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 95000) begin
      fail_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(47907));
    {nrst, reg_wr, reg_rd, sample_start, midscale_bias_enable, slow} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    sample_slot = '0;
    num_int = 8'h01;
    num_repeat = '0;
    modulation_select = '0;
    min_period = '0;
    integ_width = 5'h01;
    float_time = 8'h01;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 4; i++) reg_read(PATTERN_BASE + SLOT_STRIDE * 16'(i), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      set_pat(2'(i), d);
      reg_read(PATTERN_BASE + SLOT_STRIDE * 16'(i), pat_mem[i]);
    end
    reg_write(16'h010e, 16'hffff);
    reg_read(16'h010e, 16'h0000);
    reg_read(16'h018d, 16'h0000);
    reg_read(16'h012d, pat_mem[1]);
    set_pat(2'h0, 16'h00aa);
    run_sample(2'h0, 8'h01, 8'h04, MOD_CONT, 1'b0);
    set_pat(2'h1, 16'h9090);
    float_time <= 8'h02;
    min_period <= 10'h004;
    run_sample(2'h1, 8'h01, 8'h08, MOD_FLOAT, 1'b1);
    midscale_bias_enable <= 1'b1;
    run_sample(2'h2, 8'h01, 8'h00, MOD_CONT, 1'b0);
    for (int k = 0; k < 4; k++) begin
      sl = 2'($urandom);
      set_pat(sl, 16'($urandom));
      midscale_bias_enable <= 1'($urandom);
      integ_width <= 5'(1 + $urandom % 2);
      float_time <= 8'(1 + $urandom % 2);
      min_period <= 10'(4 + $urandom % 3);
      run_sample(sl, 8'(1 + $urandom % 2), 8'(2 + 2 * ($urandom % 2)), 2'($urandom % 3), 1'($urandom));
    end
    repeat (5) @(posedge clock);
    check(33'(nwr), 33'(nstart));
    print_verdict();
  end
endmodule
`default_nettype wire
